/* File: include/gpsc_pkg.sv */
/*
 * Constants, field layout and helpers for the sixteen-pin GPIO data path.
 * Assumes a 32-bit Wishbone register bus with byte addresses.
 */
package gpsc_pkg;

    localparam int          GPSC_PINS      = 16;
    localparam int          GPSC_ADR_W     = 8;
    localparam int          GPSC_DAT_W     = 32;

    // Register byte offsets
    localparam logic [7:0]  OFS_CFG_LOW    = 8'h00;
    localparam logic [7:0]  OFS_CFG_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_INPUT      = 8'h08;
    localparam logic [7:0]  OFS_OUTPUT     = 8'h0c;
    localparam logic [7:0]  OFS_SET_CLEAR  = 8'h10;
    localparam logic [7:0]  OFS_CLEAR_ONLY = 8'h14;

    // Reset values
    localparam logic [31:0] CFG_RESET      = 32'h4444_4444;
    localparam logic [15:0] OUTPUT_RESET   = 16'h0000;

    // Field positions
    localparam int          PIN_FIELD_W    = 4;
    localparam int          MODE_LSB       = 0;
    localparam int          KIND_LSB       = 2;
    localparam int          SET_LSB        = 0;
    localparam int          CLEAR_LSB      = 16;

    // Field codes
    localparam logic [1:0]  MODE_INPUT     = 2'h0;
    localparam logic [1:0]  KIND_ANALOG     = 2'h0;
    localparam logic [1:0]  KIND_FLOAT      = 2'h1;
    localparam logic [1:0]  KIND_PULL       = 2'h2;
    localparam logic [1:0]  KIND_OPEN_DRAIN = 2'h1;
    localparam logic [1:0]  KIND_ALT_OD     = 2'h3;

    typedef enum logic [2:0] {
        GPSC_ANALOG,
        GPSC_FLOATING,
        GPSC_PULLED,
        GPSC_PUSH_PULL,
        GPSC_OPEN_DRAIN
    } gpsc_pin_mode_t;

    // Decodes one pin's 4-bit configuration nibble
    function automatic gpsc_pin_mode_t gpsc_decode(input logic [3:0] nib);
        logic [1:0] dir;
        logic [1:0] kind;
        dir  = nib[MODE_LSB +: 2];
        kind = nib[KIND_LSB +: 2];
        if (dir == MODE_INPUT)
            gpsc_decode = (kind == KIND_PULL)   ? GPSC_PULLED :
                          (kind == KIND_ANALOG) ? GPSC_ANALOG : GPSC_FLOATING;
        else
            gpsc_decode = (kind == KIND_OPEN_DRAIN || kind == KIND_ALT_OD) ?
                          GPSC_OPEN_DRAIN : GPSC_PUSH_PULL;
    endfunction

    // Expands Wishbone byte selects into a bit mask
    function automatic logic [31:0] gpsc_lane_mask(input logic [3:0] sel);
        gpsc_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

endpackage

/* File: core/gpsc_wb_slave.sv */
/*
 * Wishbone classic handshake for the GPIO port: one wait state, registered
 * ack and read data. Assumes the master holds the request until ack.
 */
`timescale 1ns/10ps
module gpsc_wb_slave
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [31:0]                    rd_data_i,
    output logic                                wb_ack_o,
    output logic [31:0]                         wb_dat_o,
    output logic                                wr_take_o
);
    import gpsc_pkg::*;

    logic                                       first_cycle;

    assign first_cycle = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Write lands on the same edge at which the master samples ack
    assign wr_take_o   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= first_cycle;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (first_cycle && !wb_we_i)
            wb_dat_o <= rd_data_i;
    end

endmodule

/* File: core/gpsc_pin_cfg.sv */
/*
 * Per-pin pad control from the configuration nibbles and drive bits.
 * Purely combinational; the port registers every result before the pads.
 */
`timescale 1ns/10ps
module gpsc_pin_cfg
(
    input  wire logic [31:0]                    cfg_low_i,
    input  wire logic [31:0]                    cfg_high_i,
    input  wire logic [15:0]                    drive_i,
    output logic      [15:0]                    pad_out_o,
    output logic      [15:0]                    pad_oe_n_o,
    output logic      [15:0]                    pull_up_o,
    output logic      [15:0]                    pull_down_o
);
    import gpsc_pkg::*;

    logic [63:0]                                cfg_all;

    assign cfg_all = {cfg_high_i, cfg_low_i};

    for (genvar p = 0; p < GPSC_PINS; p++)
    begin : g_pin
        gpsc_pin_mode_t                         mode;
        assign mode = gpsc_decode(cfg_all[p*PIN_FIELD_W +: PIN_FIELD_W]);

        always_comb
        begin
            pad_out_o[p]   = 1'b0;
            pad_oe_n_o[p]  = 1'b1;
            pull_up_o[p]   = 1'b0;
            pull_down_o[p] = 1'b0;
            unique case (mode)
                GPSC_ANALOG, GPSC_FLOATING: ;
                GPSC_PULLED:
                begin
                    pull_up_o[p]   = drive_i[p];
                    pull_down_o[p] = !drive_i[p];
                end
                GPSC_PUSH_PULL:
                begin
                    pad_out_o[p]  = drive_i[p];
                    pad_oe_n_o[p] = 1'b0;
                end
                GPSC_OPEN_DRAIN:
                    // Only a zero is driven; a one releases the pad
                    pad_oe_n_o[p] = drive_i[p];
            endcase
        end
    end

endmodule

/* File: core/gpsc_port.sv */
/*
 * Data path of one sixteen-pin GPIO port: configuration, input sampling,
 * output data register with atomic set and clear, Wishbone classic slave.
 * Assumes pin inputs are already synchronous to clk_i.
 */
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module gpsc_port
#(
    parameter int PINS = gpsc_pkg::GPSC_PINS
)
(
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [gpsc_pkg::GPSC_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [gpsc_pkg::GPSC_DAT_W-1:0] wb_dat_i,
    output logic      [gpsc_pkg::GPSC_DAT_W-1:0] wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic [PINS-1:0]                pin_level_i,
    output logic      [PINS-1:0]                pin_drive_o,
    output logic      [PINS-1:0]                pin_oe_n_o,
    output logic      [PINS-1:0]                pin_pull_up_o,
    output logic      [PINS-1:0]                pin_pull_down_o
);
    import gpsc_pkg::*;

    if (PINS < 1 || PINS > GPSC_PINS)
    begin : g_bad_pins
        $error("gpsc_port: PINS must lie between 1 and 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////

    logic [31:0]                                pin_config_low;
    logic [31:0]                                pin_config_high;
    logic [15:0]                                pin_input_level;
    logic [15:0]                                pin_drive_bit;
    logic [15:0]                                next_drive_bit;
    logic [31:0]                                lane;
    logic [31:0]                                wr_bits;
    logic [15:0]                                pin_set_request;
    logic [15:0]                                pin_clear_request;
    logic [31:0]                                rd_data;
    logic                                       wr_take;
    logic                                       hit_cfg_low;
    logic                                       hit_cfg_high;
    logic                                       hit_output;
    logic                                       hit_set_clear;
    logic                                       hit_clear_only;
    logic [15:0]                                pad_out;
    logic [15:0]                                pad_oe_n;
    logic [15:0]                                pull_up;
    logic [15:0]                                pull_down;
    logic [15:0]                                pin_mask;

    assign pin_mask = 16'((32'h1 << PINS) - 32'h1);

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake
    ////////////////////////////////////////////////////////////////////////////

    gpsc_wb_slave u_slave
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wb_cyc_i   (wb_cyc_i),
        .wb_stb_i   (wb_stb_i),
        .wb_we_i    (wb_we_i),
        .rd_data_i  (rd_data),
        .wb_ack_o   (wb_ack_o),
        .wb_dat_o   (wb_dat_o),
        .wr_take_o  (wr_take)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and write data
    ////////////////////////////////////////////////////////////////////////////

    assign hit_cfg_low    = wr_take && (wb_adr_i == OFS_CFG_LOW);
    assign hit_cfg_high   = wr_take && (wb_adr_i == OFS_CFG_HIGH);
    assign hit_output     = wr_take && (wb_adr_i == OFS_OUTPUT);
    assign hit_set_clear  = wr_take && (wb_adr_i == OFS_SET_CLEAR);
    assign hit_clear_only = wr_take && (wb_adr_i == OFS_CLEAR_ONLY);

    // Unselected byte lanes carry no request at all
    assign lane    = gpsc_lane_mask(wb_sel_i);
    assign wr_bits = wb_dat_i & lane;

    always_comb
    begin
        pin_set_request   = 16'h0000;
        pin_clear_request = 16'h0000;
        if (hit_set_clear)
        begin
            pin_set_request   = wr_bits[SET_LSB +: 16];
            pin_clear_request = wr_bits[CLEAR_LSB +: 16];
        end
        else if (hit_clear_only)
        begin
            // Upper half is reserved and ignored
            pin_clear_request = wr_bits[SET_LSB +: 16];
        end
        pin_set_request   = pin_set_request & pin_mask;
        pin_clear_request = pin_clear_request & pin_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_config_low <= CFG_RESET;
        else if (hit_cfg_low)
            pin_config_low <= (pin_config_low & ~lane) | wr_bits;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_config_high <= CFG_RESET;
        else if (hit_cfg_high)
            pin_config_high <= (pin_config_high & ~lane) | wr_bits;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output data register
    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_drive_bit = pin_drive_bit;
        if (hit_output)
        begin
            // Byte-wide writes are merged per lane rather than refused
            next_drive_bit = (pin_drive_bit & ~lane[15:0]) | wr_bits[15:0];
        end
        // Clear first, then set, so a set wins on the same bit
        next_drive_bit = (next_drive_bit & ~pin_clear_request)
                       | pin_set_request;
        next_drive_bit = next_drive_bit & pin_mask;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_drive_bit <= OUTPUT_RESET;
        else
            pin_drive_bit <= next_drive_bit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input sampling
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_input_level <= 16'h0000;
        else
            pin_input_level <= 16'(pin_level_i);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_CFG_LOW:    rd_data = pin_config_low;
            OFS_CFG_HIGH:   rd_data = pin_config_high;
            // Reserved upper halves read as zero
            OFS_INPUT:      rd_data = {16'h0000, pin_input_level};
            OFS_OUTPUT:     rd_data = {16'h0000, pin_drive_bit};
            // Write-only registers and holes read as zero
            default:        rd_data = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad control
    ////////////////////////////////////////////////////////////////////////////

    gpsc_pin_cfg u_pin_cfg
    (
        .cfg_low_i   (pin_config_low),
        .cfg_high_i  (pin_config_high),
        .drive_i     (pin_drive_bit),
        .pad_out_o   (pad_out),
        .pad_oe_n_o  (pad_oe_n),
        .pull_up_o   (pull_up),
        .pull_down_o (pull_down)
    );

    // Pads follow the registers one cycle later; outputs stay glitch free
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_drive_o <= '0;
            pin_oe_n_o  <= '1;
        end
        else
        begin
            pin_drive_o <= pad_out[PINS-1:0];
            pin_oe_n_o  <= pad_oe_n[PINS-1:0];
        end
    end

    // After reset every pin is a floating input, so no pull is active
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_pull_up_o   <= '0;
            pin_pull_down_o <= '0;
        end
        else
        begin
            pin_pull_up_o   <= pull_up[PINS-1:0];
            pin_pull_down_o <= pull_down[PINS-1:0];
        end
    end

endmodule

/* File: test/gpsc_pins_model.sv */
/*
 * Model of the sixteen external pads: resolves each pad level from the
 * port's drive, the bench's forcing source and the pull enables.
 * Assumes the bench never forces a pad that the port is driving.
 */
`timescale 1ns/10ps
module gpsc_pins_model
(
    input  wire logic        clk_i,
    input  wire logic [15:0] drive_i,
    input  wire logic [15:0] oe_n_i,
    input  wire logic [15:0] pull_up_i,
    input  wire logic [15:0] pull_down_i,
    input  wire logic [15:0] ext_val_i,
    input  wire logic [15:0] ext_en_i,
    output logic      [15:0] level_o
);
    logic [15:0] wobble = 16'h5a5a;

    // A floating pad toggles so no settled value passes for a real level
    always @(posedge clk_i)
        wobble <= ~wobble;

    always_comb
        for (int i = 0; i < 16; i++)
            level_o[i] = !oe_n_i[i] ? drive_i[i] : ext_en_i[i] ? ext_val_i[i] :
                pull_up_i[i] ? 1'b1 : pull_down_i[i] ? 1'b0 : wobble[i];
endmodule

/* File: test/gpsc_port_chk.sv */
/*
 * Concurrent checks on the GPIO port pins and Wishbone side.
 * Assumes PINS is 16 and the master holds each request until ack.
 */
`timescale 1ns/10ps
module gpsc_port_chk
    import gpsc_pkg::*;
#(
    parameter int PINS = 16
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [GPSC_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [GPSC_DAT_W-1:0] wb_dat_i,
    input  wire logic [GPSC_DAT_W-1:0] wb_dat_o,
    input  wire logic                  wb_ack_o,
    input  wire logic [PINS-1:0]       pin_level_i,
    input  wire logic [PINS-1:0]       pin_drive_o,
    input  wire logic [PINS-1:0]       pin_oe_n_o,
    input  wire logic [PINS-1:0]       pin_pull_up_o,
    input  wire logic [PINS-1:0]       pin_pull_down_o
);
    logic [15:0] sh;
    logic [15:0] lo_m;
    logic [15:0] hi_m;
    logic        wr_done;
    logic        rd;

    assign lo_m    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign hi_m    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}};
    assign wr_done = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    assign rd      = wb_ack_o && !wb_we_i;

    // Shadow of the output data; clear applied first so a set wins
    always_ff @(posedge clk_i)
        if (rst_i)
            sh <= 16'h0;
        else if (wr_done && wb_adr_i == OFS_OUTPUT)
            sh <= (sh & ~lo_m) | (wb_dat_i[15:0] & lo_m);
        else if (wr_done && wb_adr_i == OFS_SET_CLEAR)
            sh <= (sh & ~(wb_dat_i[31:16] & hi_m)) | (wb_dat_i[15:0] & lo_m);
        else if (wr_done && wb_adr_i == OFS_CLEAR_ONLY)
            sh <= sh & ~(wb_dat_i[15:0] & lo_m);

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one wait state");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_reset_pads: assert property (disable iff (1'b0) rst_i |=> pin_drive_o == '0
        && (&pin_oe_n_o) && !wb_ack_o && pin_pull_up_o == '0)
        else $error("pads not at reset values");
    a_out_readback: assert property ((rd && wb_adr_i == OFS_OUTPUT)
        |-> wb_dat_o == 32'(sh))
        else $error("output data differs from set and clear history");
    a_in_readback: assert property ((rd && wb_adr_i == OFS_INPUT)
        |-> wb_dat_o == 32'($past(pin_level_i, 2)))
        else $error("input read differs from sampled pins");
    a_wo_read_zero: assert property ((rd && wb_adr_i >= OFS_SET_CLEAR)
        |-> wb_dat_o == '0)
        else $error("write-only or unmapped place read nonzero");
    a_pull_choice: assert property (((pin_pull_up_o & ~$past(sh))
        | (pin_pull_down_o & $past(sh))) == '0)
        else $error("pull direction disagrees with output data");
    a_pull_released: assert property ((pin_pull_up_o & pin_pull_down_o) == '0
        && ((pin_pull_up_o | pin_pull_down_o) & ~pin_oe_n_o) == '0)
        else $error("pull on a driven pad or both pulls on");

    c_set_clear: cover property (wr_done && wb_adr_i == OFS_SET_CLEAR);
    c_in_read: cover property (rd && wb_adr_i == OFS_INPUT);
    c_pull_up: cover property (|pin_pull_up_o);
endmodule

bind gpsc_port gpsc_port_chk #(.PINS(PINS)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_level_i,
    .pin_drive_o, .pin_oe_n_o, .pin_pull_up_o, .pin_pull_down_o);

/* File: test/test_gpsc_port.sv */
/*
 * Self-checking bench for the GPIO port: bus reads and writes, set and
 * clear traffic, pad and pull checks. Assumes the pins model beside it.
 */
`timescale 1ns/10ps
module test_gpsc_port;
    import gpsc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic [15:0] lvl, drv, oe_n, pu, pd;
    logic [15:0] ext_val = 16'h0;
    logic [15:0] ext_en  = 16'h0;
    logic [15:0] exp_out = 16'h0;
    // Pad mode under test: 0 push-pull, 1 open drain, 2 pulled, 3 released
    int          mode    = 0;
    int          err_count   = 0;
    int          check_count = 0;

    gpsc_port u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_level_i(lvl), .pin_drive_o(drv), .pin_oe_n_o(oe_n), .pin_pull_up_o(pu),
        .pin_pull_down_o(pd));
    gpsc_pins_model u_pins (.clk_i, .drive_i(drv), .oe_n_i(oe_n), .pull_up_i(pu),
        .pull_down_i(pd), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(lvl));

    initial
        forever #4 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h want %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h1, 32'h0);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Expected output data; clear goes first so a set in the same write wins
    function automatic logic [15:0] nxt(input logic [15:0] c, input logic [7:0] a,
                                        input logic [3:0] s, input logic [31:0] d);
        logic [15:0] lm;
        logic [15:0] hm;
        lm = {{8{s[1]}}, {8{s[0]}}};
        hm = {{8{s[3]}}, {8{s[2]}}};
        if (a == OFS_OUTPUT) return (c & ~lm) | (d[15:0] & lm);
        if (a == OFS_SET_CLEAR) return (c & ~(d[31:16] & hm)) | (d[15:0] & lm);
        if (a == OFS_CLEAR_ONLY) return c & ~(d[15:0] & lm);
        return c;
    endfunction

    task automatic op(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        xfer(1'b1, a, s, d, q);
        exp_out = nxt(exp_out, a, s, d);
        xfer(1'b0, OFS_OUTPUT, 4'hf, 32'h0, q);
        chk(q, {16'h0, exp_out});
        case (mode)
            0: chk({drv, oe_n}, {exp_out, 16'h0});
            1: chk({drv, oe_n}, {16'h0, exp_out});
            default: chk({drv, oe_n}, {16'h0, 16'hffff});
        endcase
        chk({pu, pd}, (mode == 2) ? {exp_out, ~exp_out} : 32'h0);
    endtask

    // Pads of a port fresh out of reset: all released, no pull
    task automatic chk_idle();
        chk({drv, oe_n}, {16'h0, 16'hffff});
        chk({pu, pd}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        close_out();
    end

    initial
    begin
        void'($urandom(90652));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_idle();
        xfer(1'b0, OFS_OUTPUT, 4'hf, 32'h0, q); chk(q, 32'h0);
        xfer(1'b0, OFS_SET_CLEAR, 4'hf, 32'h0, q); chk(q, 32'h0);
        xfer(1'b0, OFS_CLEAR_ONLY, 4'hf, 32'h0, q); chk(q, 32'h0);
        xfer(1'b0, 8'h1c, 4'hf, 32'h0, q); chk(q, 32'h0);
        // High pins take the alternate push-pull code, which must not pull
        xfer(1'b1, OFS_CFG_LOW, 4'hf, 32'h1111_1111, q);
        xfer(1'b1, OFS_CFG_HIGH, 4'hf, 32'h9999_9999, q);
        op(OFS_SET_CLEAR, 4'hf, 32'hffff_ffff);
        op(OFS_SET_CLEAR, 4'hf, 32'hffff_0000);
        op(OFS_OUTPUT, 4'h3, 32'h0000_a5c3);
        op(OFS_CLEAR_ONLY, 4'hf, 32'hffff_0081);
        for (int i = 0; i < 40; i++)
        begin
            case ($urandom % 4)
                0: op(OFS_OUTPUT, 4'h3, $urandom);
                1: op(OFS_SET_CLEAR, 4'h3, $urandom);
                2: op(OFS_SET_CLEAR, 4'hc, $urandom);
                default: op(OFS_CLEAR_ONLY, 4'h3, $urandom);
            endcase
        end
        xfer(1'b1, OFS_INPUT, 4'hf, 32'hffff_ffff, q);
        xfer(1'b0, OFS_INPUT, 4'hf, 32'h0, q); chk(q, {16'h0, exp_out});
        // Open drain, general on the low pins and alternate on the high ones
        mode = 1;
        xfer(1'b1, OFS_CFG_LOW, 4'hf, 32'h5555_5555, q);
        xfer(1'b1, OFS_CFG_HIGH, 4'hf, 32'hdddd_dddd, q);
        for (int i = 0; i < 6; i++)
        begin
            op(OFS_SET_CLEAR, 4'h3, $urandom);
            op(OFS_SET_CLEAR, 4'hc, $urandom);
        end
        mode = 2;
        xfer(1'b1, OFS_CFG_LOW, 4'hf, 32'h8888_8888, q);
        xfer(1'b1, OFS_CFG_HIGH, 4'hf, 32'h8888_8888, q);
        for (int i = 0; i < 8; i++)
        begin
            op(OFS_OUTPUT, 4'h3, $urandom);
            xfer(1'b0, OFS_INPUT, 4'hf, 32'h0, q); chk(q, {16'h0, exp_out});
            ext_en <= 16'hffff;
            ext_val <= 16'($urandom);
            repeat (3) @(posedge clk_i);
            xfer(1'b0, OFS_INPUT, 4'hf, 32'h0, q); chk(q, {16'h0, ext_val});
            ext_en <= 16'h0;
        end
        // Reset in mid-run returns every pad to a released input
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        exp_out = 16'h0;
        mode = 3;
        chk_idle();
        op(OFS_SET_CLEAR, 4'h3, 32'h0000_00ff);
        // Analog code on the low pins keeps them released as well
        xfer(1'b1, OFS_CFG_LOW, 4'hf, 32'h0000_0000, q);
        op(OFS_SET_CLEAR, 4'hc, 32'h000f_0000);
        close_out();
    end
endmodule
